// ---- fcb_backend.v ----
// fcb_backend.v - fragment colour back end: texture, fog, blend, format, logic op, fill
`timescale 1ns/1ps
`default_nettype none
`include "fcb_map.vh"

module fcb_backend #(
  parameter CW = 16
) (
  // clock, reset, enable
  input wire clk,
  input wire reset_n,
  input wire ce,
  // ahb-lite slave
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output reg hreadyout,
  output reg [31:0] hrdata,
  output reg hresp,
  // interpolator stepping from the rasterizer
  input wire prim_start,
  input wire edge_step,
  // fragment in
  input wire frag_valid,
  input wire [CW-1:0] frag_x,
  input wire [CW-1:0] frag_y,
  input wire [31:0] frag_color,
  input wire frag_tex_apply,
  input wire frag_fog_apply,
  input wire frag_mask_fail,
  input wire frag_is_line,
  input wire [31:0] frag_dest,
  // texture read unit
  input wire texel_load,
  input wire [31:0] texel_in,
  // pixel out
  output reg pix_valid,
  output reg [CW-1:0] pix_x,
  output reg [CW-1:0] pix_y,
  output reg [31:0] pix_data
);

  // product of two 0..255 fractions, rounded
  function [7:0] mul8;
    input [7:0] a;
    input [7:0] b;
    reg [15:0] p;
    begin
      p = a * b;
      p = p + {8'h00, p[15:8]} + 16'h0080;
      mul8 = p[15:8];
    end
  endfunction

  // clamp a 9-bit sum to the component maximum
  function [7:0] sat8;
    input [8:0] s;
    begin
      sat8 = s[8] ? 8'hFF : s[7:0];
    end
  endfunction

  // a times w plus b times one minus w
  function [7:0] mix;
    input [7:0] a;
    input [7:0] b;
    input [7:0] w;
    begin
      mix = sat8({1'b0, mul8(a, w)} + {1'b0, mul8(b, ~w)});
    end
  endfunction

  // signed 2.16 value clamped to 0..1 as an 8-bit fraction
  function [7:0] k8;
    input [17:0] v;
    begin
      if (v[17])
        k8 = 8'h00;
      else if (v[16])
        k8 = 8'hFF;
      else
        k8 = v[15:8];
    end
  endfunction

  // 4x4 ordered dither threshold
  function [3:0] bay;
    input [1:0] x;
    input [1:0] y;
    begin
      bay = {x[0] ^ y[0], y[0], x[1] ^ y[1], y[1]};
    end
  endfunction

  // add dither bias then keep the top n bits, low aligned
  function [7:0] dq;
    input [7:0] c;
    input [3:0] n;
    input [3:0] d;
    reg [11:0] b;
    reg [7:0] s;
    begin
      b = {4'h0, d, 4'h0} >> n;
      s = sat8({1'b0, c} + {1'b0, b[7:0]});
      dq = s >> (4'h8 - n);
    end
  endfunction

  // internal rgba to raw framebuffer word
  function [31:0] pack;
    input [31:0] c;
    input [4:0] fm;
    input bgr;
    input de;
    input [3:0] d;
    reg [7:0] r, g, b, a, q0, q1, q2, q3;
    begin
      r = bgr ? c[23:16] : c[7:0];
      g = c[15:8];
      b = bgr ? c[7:0] : c[23:16];
      a = c[31:24];
      q0 = 8'h00;
      q1 = 8'h00;
      q2 = 8'h00;
      q3 = 8'h00;
      case (fm)
        `FCB_F_5551: begin
          q0 = dq(r, 4'h5, d);
          q1 = dq(g, 4'h5, d);
          q2 = dq(b, 4'h5, d);
          q3 = dq(a, 4'h1, d);
          pack = {16'h0000, q3[0], q2[4:0], q1[4:0], q0[4:0]};
        end
        `FCB_F_565: begin
          q0 = dq(r, 4'h5, d);
          q1 = dq(g, 4'h6, d);
          q2 = dq(b, 4'h5, d);
          pack = {16'h0000, q2[4:0], q1[5:0], q0[4:0]};
        end
        `FCB_F_332, `FCB_F_332FB: begin
          q0 = dq(r, 4'h3, d);
          q1 = dq(g, 4'h3, d);
          q2 = dq(b, 4'h2, d);
          if (fm == `FCB_F_332FB)
            pack = {16'h0000, q2[1:0], q1[2:0], q0[2:0], q2[1:0], q1[2:0], q0[2:0]};
          else
            pack = {24'h000000, q2[1:0], q1[2:0], q0[2:0]};
        end
        `FCB_F_CI8: begin
          q0 = dq(c[7:0], 4'h8, 4'h0);
          pack = {q0, q0, q0, q0};
        end
        `FCB_F_888: begin
          if (de) begin
            q0 = dq(r, 4'h5, d);
            q1 = dq(g, 4'h5, d);
            q2 = dq(b, 4'h5, d);
            q3 = dq(a, 4'h1, d);
            pack = {{8{q3[0]}}, q2[4:0], 3'h0, q1[4:0], 3'h0, q0[4:0], 3'h0};
          end else begin
            pack = {a, b, g, r};
          end
        end
        default: pack = {a, b, g, r};
      endcase
    end
  endfunction

  // raw framebuffer word to internal rgba
  function [31:0] unp;
    input [31:0] w;
    input [4:0] fm;
    input bgr;
    input na;
    reg [7:0] r, g, b, a;
    begin
      r = w[7:0];
      g = w[15:8];
      b = w[23:16];
      a = w[31:24];
      case (fm)
        `FCB_F_5551: begin
          r = {w[4:0], 3'h0};
          g = {w[9:5], 3'h0};
          b = {w[14:10], 3'h0};
          a = {8{w[15]}};
        end
        `FCB_F_565: begin
          r = {w[4:0], 3'h0};
          g = {w[10:5], 2'h0};
          b = {w[15:11], 3'h0};
          a = 8'hFF;
        end
        `FCB_F_332, `FCB_F_332FB: begin
          r = {w[2:0], 5'h00};
          g = {w[5:3], 5'h00};
          b = {w[7:6], 6'h00};
          a = 8'hFF;
        end
        `FCB_F_CI8: begin
          g = w[7:0];
          b = w[7:0];
          a = 8'hFF;
        end
        default: a = w[31:24];
      endcase
      if (na)
        a = 8'hFF;
      unp = bgr ? {a, r, g, b} : {a, b, g, r};
    end
  endfunction

  // one of sixteen bitwise functions, one code bit per source/dest pair
  function [31:0] lop;
    input [3:0] op;
    input [31:0] s;
    input [31:0] d;
    begin
      lop = ({32{op[0]}} & s & d) | ({32{op[1]}} & s & ~d) |
        ({32{op[2]}} & ~s & d) | ({32{op[3]}} & ~s & ~d);
    end
  endfunction

  reg [31:0] texel_apply_control;
  reg [31:0] texel_hold_value;
  reg [31:0] haze_control;
  reg [31:0] haze_colour_value;
  reg [31:0] blend_control;
  reg [31:0] pixel_format_control;
  reg [31:0] bitwise_op_control;
  reg [31:0] constant_pixel_value;
  reg [17:0] dda_par [0:8];
  reg [17:0] dda_edge [0:2];
  reg [17:0] dda_cur [0:2];
  reg [15:0] pix_cnt;
  reg [15:0] drop_cnt;
  reg [3:0] line_cnt;
  reg ap_wr;
  reg [7:0] ap_addr;
  reg [31:0] next_rdata;
  reg [31:0] c, tex, d, raw;
  reg [7:0] as, f8, kd, ks;
  reg [3:0] dv;
  reg [1:0] dx, dy;
  reg drop;
  integer i, k;

  // address phase decode
  wire acc = hsel & htrans[1] & hready;
  wire [7:0] rd_off = haddr - `FCB_A_DDA_FIRST;
  wire [7:0] wr_off = ap_addr - `FCB_A_DDA_FIRST;
  wire rd_dda = (haddr >= `FCB_A_DDA_FIRST) && (haddr <= `FCB_A_DDA_LAST);
  wire wr_dda = (ap_addr >= `FCB_A_DDA_FIRST) && (ap_addr <= `FCB_A_DDA_LAST);
  wire [2:0] dda_en = {1'b1, texel_apply_control[`FCB_T_DIFF],
    texel_apply_control[`FCB_T_SPEC]};

  // read data mux, sampled at the address phase
  always @* begin
    next_rdata = `FCB_RST;
    if (haddr[1:0] != 2'h0)
      next_rdata = `FCB_RST;
    else if (haddr == `FCB_A_TEX_CTL)
      next_rdata = texel_apply_control;
    else if (haddr == `FCB_A_TEXEL)
      next_rdata = texel_hold_value;
    else if (rd_dda)
      next_rdata = {{14{dda_par[rd_off[5:2]][17]}}, dda_par[rd_off[5:2]]};
    else if (haddr == `FCB_A_HAZE_CTL)
      next_rdata = haze_control;
    else if (haddr == `FCB_A_HAZE_COL)
      next_rdata = haze_colour_value;
    else if (haddr == `FCB_A_BLEND)
      next_rdata = blend_control;
    else if (haddr == `FCB_A_PIXFMT)
      next_rdata = pixel_format_control;
    else if (haddr == `FCB_A_BITOP)
      next_rdata = bitwise_op_control;
    else if (haddr == `FCB_A_CONST)
      next_rdata = constant_pixel_value;
    else if (haddr == `FCB_A_STATUS)
      next_rdata = {drop_cnt, pix_cnt};
  end

  // fragment colour path, one stage feeding the next
  always @* begin
    tex = texel_load ? texel_in : texel_hold_value;
    c = frag_mask_fail ? tex : frag_color;
    kd = k8(dda_cur[1]);
    ks = k8(dda_cur[0]);
    f8 = k8(dda_cur[2]);
    as = 8'h00;
    d = unp(frag_dest, {blend_control[`FCB_B_EXT], blend_control[`FCB_B_FMT]},
      blend_control[`FCB_B_BGR], blend_control[`FCB_B_NOALPHA]);
    // texture stage
    if (texel_apply_control[`FCB_T_EN] && frag_tex_apply) begin
      if (texel_apply_control[`FCB_T_RAMP]) begin
        for (k = 0; k < 3; k = k + 1)
          c[8*k +: 8] = texel_apply_control[`FCB_T_DECAL] ?
            mix(tex[8*k +: 8], c[8*k +: 8], tex[31:24]) : tex[8*k +: 8];
        if (!texel_apply_control[`FCB_T_DECAL])
          c[31:24] = mul8(tex[31:24], c[31:24]);
        if (texel_apply_control[`FCB_T_MOD])
          for (k = 0; k < 4; k = k + 1)
            c[8*k +: 8] = mul8(kd, c[8*k +: 8]);
        if (texel_apply_control[`FCB_T_HIGH])
          for (k = 0; k < 4; k = k + 1)
            c[8*k +: 8] = sat8({1'b0, c[8*k +: 8]} + {1'b0, ks});
      end else begin
        case (texel_apply_control[`FCB_T_MODE])
          `FCB_RGB_COPY: c = tex;
          `FCB_RGB_DECAL:
            for (k = 0; k < 3; k = k + 1)
              c[8*k +: 8] = mix(tex[8*k +: 8], c[8*k +: 8], tex[31:24]);
          `FCB_RGB_MOD:
            for (k = 0; k < 4; k = k + 1)
              c[8*k +: 8] = mul8(tex[8*k +: 8], c[8*k +: 8]);
          default: c = c;
        endcase
      end
    end
    // fog stage, alpha untouched
    if (haze_control[`FCB_H_EN] && frag_fog_apply)
      for (k = 0; k < 3; k = k + 1)
        c[8*k +: 8] = mix(c[8*k +: 8], haze_colour_value[8*k +: 8], f8);
    drop = haze_control[`FCB_H_TEST] & dda_cur[2][17];
    // alpha blend stage
    if (blend_control[`FCB_B_EN]) begin
      as = c[31:24];
      for (k = 0; k < 3; k = k + 1) begin
        if (blend_control[`FCB_B_OP] == `FCB_OP_BLEND)
          c[8*k +: 8] = mix(c[8*k +: 8], d[8*k +: 8], as);
        else if (blend_control[`FCB_B_OP] == `FCB_OP_PREMULTIPLIED_BLEND)
          c[8*k +: 8] = sat8({1'b0, c[8*k +: 8]} + {1'b0, mul8(d[8*k +: 8], ~as)});
      end
    end
    // dither threshold from shifted coordinates or line position
    dx = frag_x[1:0] + pixel_format_control[`FCB_P_XS];
    dy = frag_y[1:0] + pixel_format_control[`FCB_P_YS];
    dv = 4'h0;
    if (pixel_format_control[`FCB_P_DITH]) begin
      if (frag_is_line && pixel_format_control[`FCB_P_LINE])
        dv = bay(line_cnt[1:0], line_cnt[3:2]);
      else
        dv = bay(dx, dy);
    end
    // colour format stage
    if (pixel_format_control[`FCB_P_EN]) begin
      if (pixel_format_control[`FCB_P_AO] == `FCB_AO_ZERO)
        c[31:24] = 8'h00;
      else if (pixel_format_control[`FCB_P_AO] == `FCB_AO_MAX)
        c[31:24] = `FCB_ALPHA_MAX;
      raw = pack(c, {pixel_format_control[`FCB_P_EXT], pixel_format_control[`FCB_P_FMT]},
        pixel_format_control[`FCB_P_BGR], pixel_format_control[`FCB_P_DITH], dv);
    end else begin
      raw = c;
    end
    // logic op stage and constant fill bypass
    if (bitwise_op_control[`FCB_L_EN])
      raw = lop(bitwise_op_control[`FCB_L_OP], raw, frag_dest);
    if (bitwise_op_control[`FCB_L_CONST])
      raw = constant_pixel_value;
  end

  // bus slave, registers, interpolators and pixel output
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= `FCB_RST;
      ap_wr <= 1'b0;
      ap_addr <= 8'h00;
      texel_apply_control <= `FCB_RST;
      texel_hold_value <= `FCB_RST;
      haze_control <= `FCB_RST;
      haze_colour_value <= `FCB_RST;
      blend_control <= `FCB_RST;
      pixel_format_control <= `FCB_RST;
      bitwise_op_control <= `FCB_RST;
      constant_pixel_value <= `FCB_RST;
      for (i = 0; i < 9; i = i + 1)
        dda_par[i] <= 18'h00000;
      for (i = 0; i < 3; i = i + 1) begin
        dda_edge[i] <= 18'h00000;
        dda_cur[i] <= 18'h00000;
      end
      pix_cnt <= 16'h0000;
      drop_cnt <= 16'h0000;
      line_cnt <= 4'h0;
      pix_valid <= 1'b0;
      pix_x <= {CW{1'b0}};
      pix_y <= {CW{1'b0}};
      pix_data <= `FCB_RST;
    end else if (ce) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      ap_wr <= acc & hwrite & (hsize == `FCB_HSIZE_WORD) & (haddr[1:0] == 2'h0);
      if (acc) begin
        ap_addr <= haddr;
        hrdata <= next_rdata;
      end
      // data phase write
      if (ap_wr) begin
        if (ap_addr == `FCB_A_TEX_CTL)
          texel_apply_control <= hwdata;
        else if (wr_dda)
          dda_par[wr_off[5:2]] <= hwdata[17:0];
        else if (ap_addr == `FCB_A_HAZE_CTL)
          haze_control <= hwdata;
        else if (ap_addr == `FCB_A_HAZE_COL)
          haze_colour_value <= hwdata;
        else if (ap_addr == `FCB_A_BLEND)
          blend_control <= hwdata;
        else if (ap_addr == `FCB_A_PIXFMT)
          pixel_format_control <= hwdata;
        else if (ap_addr == `FCB_A_BITOP)
          bitwise_op_control <= hwdata;
        else if (ap_addr == `FCB_A_CONST)
          constant_pixel_value <= hwdata;
      end
      // texture reader wins over a host write in the same cycle
      if (texel_load)
        texel_hold_value <= texel_in;
      else if (ap_wr && ap_addr == `FCB_A_TEXEL)
        texel_hold_value <= hwdata;
      // interpolators: start, edge step, then x step per fragment
      for (i = 0; i < 3; i = i + 1) begin
        if (!dda_en[i]) begin
          dda_edge[i] <= 18'h00000;
          dda_cur[i] <= 18'h00000;
        end else if (prim_start) begin
          dda_edge[i] <= dda_par[3*i];
          dda_cur[i] <= dda_par[3*i];
        end else if (edge_step) begin
          dda_edge[i] <= dda_edge[i] + dda_par[3*i+2];
          dda_cur[i] <= dda_edge[i] + dda_par[3*i+2];
        end else if (frag_valid) begin
          dda_cur[i] <= dda_cur[i] + dda_par[3*i+1];
        end
      end
      // line position for orientation independent dither
      if (prim_start)
        line_cnt <= 4'h0;
      else if (frag_valid && frag_is_line)
        line_cnt <= line_cnt + 4'h1;
      // pixel out and counters
      pix_valid <= frag_valid & ~drop;
      if (frag_valid) begin
        pix_x <= frag_x;
        pix_y <= frag_y;
        pix_data <= raw;
        if (drop)
          drop_cnt <= drop_cnt + 16'h0001;
        else
          pix_cnt <= pix_cnt + 16'h0001;
      end
    end
  end

endmodule
`default_nettype wire

// ---- fcb_map.vh ----
// fcb_map.vh - register offsets, field positions, codes and reset values of the colour back end
`ifndef FCB_MAP_VH
`define FCB_MAP_VH
// register byte offsets
`define FCB_A_TEX_CTL 8'h00
`define FCB_A_TEXEL 8'h04
`define FCB_A_DDA_FIRST 8'h08
`define FCB_A_DDA_LAST 8'h28
`define FCB_A_HAZE_CTL 8'h2C
`define FCB_A_HAZE_COL 8'h30
`define FCB_A_BLEND 8'h34
`define FCB_A_PIXFMT 8'h38
`define FCB_A_BITOP 8'h3C
`define FCB_A_CONST 8'h40
`define FCB_A_STATUS 8'h44
`define FCB_RST 32'h00000000
`define FCB_HSIZE_WORD 3'h2
// texel_apply_control fields
`define FCB_T_EN 0
`define FCB_T_RAMP 1
`define FCB_T_MODE 3:2
`define FCB_T_DECAL 4
`define FCB_T_MOD 5
`define FCB_T_HIGH 6
`define FCB_T_SPEC 7
`define FCB_T_DIFF 8
`define FCB_RGB_COPY 2'h0
`define FCB_RGB_DECAL 2'h1
`define FCB_RGB_MOD 2'h2
// haze_control fields
`define FCB_H_EN 0
`define FCB_H_TEST 1
// blend_control fields
`define FCB_B_EN 0
`define FCB_B_OP 2:1
`define FCB_B_FMT 6:3
`define FCB_B_EXT 7
`define FCB_B_BGR 8
`define FCB_B_NOALPHA 9
`define FCB_OP_FORMAT 2'h0
`define FCB_OP_BLEND 2'h1
`define FCB_OP_PREMULTIPLIED_BLEND 2'h2
// pixel_format_control fields
`define FCB_P_EN 0
`define FCB_P_DITH 1
`define FCB_P_FMT 5:2
`define FCB_P_EXT 6
`define FCB_P_BGR 7
`define FCB_P_XS 9:8
`define FCB_P_YS 11:10
`define FCB_P_AO 13:12
`define FCB_P_LINE 14
`define FCB_AO_ZERO 2'h1
`define FCB_AO_MAX 2'h2
`define FCB_ALPHA_MAX 8'hF8
// bitwise_op_control fields
`define FCB_L_EN 0
`define FCB_L_OP 4:1
`define FCB_L_CONST 5
// framebuffer depth codes, {extension, format}
`define FCB_F_8888 5'h00
`define FCB_F_5551 5'h01
`define FCB_F_565 5'h02
`define FCB_F_332 5'h03
`define FCB_F_332FB 5'h04
`define FCB_F_CI8 5'h05
`define FCB_F_888 5'h10
`endif

// ---- fcb_backend_monitor.sv ----
// concurrent checks on the ports of the colour back end
`timescale 1ns/1ps
`default_nettype none
`include "fcb_map.vh"
module fcb_backend_monitor #(
  parameter CW = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  // bus
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  // fragments and pixels
  input wire logic frag_valid,
  input wire logic [CW-1:0] frag_x,
  input wire logic [CW-1:0] frag_y,
  input wire logic pix_valid,
  input wire logic [CW-1:0] pix_x,
  input wire logic [CW-1:0] pix_y,
  input wire logic [31:0] pix_data
);
  logic wp;
  logic [7:0] wa;
  logic [5:0] bitop;
  logic hz_test;
  logic [31:0] cst;
  // shadow of the host writes that steer the fragment result
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wp <= 1'h0;
      wa <= 8'h00;
      bitop <= 6'h00;
      hz_test <= 1'h0;
      cst <= 32'h00000000;
    end else if (ce && hready) begin
      wp <= hsel && htrans[1] && hwrite;
      wa <= haddr;
      if (wp && wa == `FCB_A_BITOP) bitop <= hwdata[5:0];
      if (wp && wa == `FCB_A_HAZE_CTL) hz_test <= hwdata[1];
      if (wp && wa == `FCB_A_CONST) cst <= hwdata;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_frag(logic [5:0] code);
    frag_valid && bitop == code;
  endsequence
  sequence s_out(logic [31:0] val);
    ##1 pix_valid && pix_data == val;
  endsequence
  chk_logic_clear: assert property (s_frag(6'h01) |-> s_out(32'h00000000))
    else $error("clear op did not give zero");
  chk_logic_set: assert property (s_frag(6'h1F) |-> s_out(32'hFFFFFFFF))
    else $error("set op did not give all ones");
  chk_fill_raw: assert property (frag_valid && bitop[5] |=> pix_valid && pix_data == cst)
    else $error("constant fill did not write the constant");
  chk_fog_keep: assert property (frag_valid && !hz_test |=> pix_valid)
    else $error("fragment lost without fog test");
  chk_idle_quiet: assert property (!frag_valid |=> !pix_valid)
    else $error("pixel without fragment");
  chk_xy_follow: assert property (frag_valid |=> pix_x == $past(frag_x) && pix_y == $past(frag_y))
    else $error("pixel coordinates wrong");
  chk_ready_high: assert property (hreadyout)
    else $error("wait state inserted");
  chk_resp_okay: assert property (!hresp)
    else $error("error response given");
  chk_mapless_read: assert property (hsel && htrans[1] && hready && !hwrite && haddr > 8'h44
    |=> hrdata == 32'h00000000)
    else $error("unmapped read not zero");
endmodule
`default_nettype wire

// ---- fcb_fb_model.sv ----
// framebuffer read path and pixel store facing the back end
`timescale 1ns/1ps
`default_nettype none
module fcb_fb_model #(
  parameter CW = 16
) (
  // core clock
  input wire logic clk,
  // column of the fragment in flight
  input wire logic [CW-1:0] frag_x,
  output logic [31:0] frag_dest,
  // pixel writes from the back end
  input wire logic pix_valid,
  input wire logic [CW-1:0] pix_x,
  input wire logic [31:0] pix_data
);
  logic [31:0] mem [0:15];
  integer i;
  // preset raw 8888 words, distinct per column
  initial begin
    for (i = 0; i < 16; i++) mem[i] = {28'h5A3C000, i[3:0]};
  end
  // raw stored word returned for the fragment's column
  assign frag_dest = mem[frag_x[3:0]];
  // store every pixel written, constant fill included
  always @(posedge clk) begin
    if (pix_valid) mem[pix_x[3:0]] <= pix_data;
  end
endmodule
`default_nettype wire

// ---- fcb_backend_tb.sv ----
// self-checking testbench of the colour back end
`timescale 1ns/1ps
`default_nettype none
`include "fcb_map.vh"
module fcb_backend_tb;
  localparam CW = 16;
  localparam [31:0] C = 32'h80402010;
  localparam [31:0] T = 32'h11223344;
  logic clk = 1'h0;
  logic reset_n = 1'h0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h00000000;
  logic prim_start = 1'h0;
  logic edge_step = 1'h0;
  logic frag_valid = 1'h0;
  logic ft = 1'h0;
  logic ff = 1'h0;
  logic fm = 1'h0;
  logic is_line = 1'h0;
  logic [CW-1:0] fx = 16'h0000;
  logic [CW-1:0] fy = 16'h0003;
  logic [31:0] fc = 32'h00000000;
  logic tl = 1'h0;
  logic [31:0] ti = 32'h00000000;
  logic [3:0] op;
  wire hreadyout;
  wire hresp;
  wire pv;
  wire [31:0] hrdata;
  wire [31:0] fd;
  wire [31:0] pd;
  wire [CW-1:0] px;
  wire [CW-1:0] py;
  logic [31:0] q;
  integer err_count = 0;
  integer checks_done = 0;
  integer i;
  // clock at 250 MHz
  always #2 clk = ~clk;
  fcb_backend #(.CW(CW)) i_fcb_backend (.clk(clk), .reset_n(reset_n), .ce(1'h1),
    .hsel(1'h1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .prim_start(prim_start), .edge_step(edge_step),
    .frag_valid(frag_valid), .frag_x(fx), .frag_y(fy), .frag_color(fc),
    .frag_tex_apply(ft), .frag_fog_apply(ff), .frag_mask_fail(fm),
    .frag_is_line(is_line), .frag_dest(fd), .texel_load(tl),
    .texel_in(ti), .pix_valid(pv), .pix_x(px), .pix_y(py), .pix_data(pd));
  fcb_fb_model #(.CW(CW)) i_fcb_fb_model (.clk(clk), .frag_x(fx), .frag_dest(fd),
    .pix_valid(pv), .pix_x(px), .pix_data(pd));
  // compare one word
  task chk(input string nm, input [31:0] e, input [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one single-word bus transfer, read data left in q
  task bus(input w, input [7:0] a, input [31:0] d);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= `FCB_HSIZE_WORD;
    @(posedge clk);
    while (hreadyout !== 1'h1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'h1) @(posedge clk);
    q = hrdata;
  endtask
  task rd(input [7:0] a, input [31:0] e);
    bus(1'h0, a, 32'h00000000);
    chk("hrdata", e, q);
  endtask
  // one fragment; expected pixel compared under mask k
  task frag(input [31:0] c, input [15:0] x, input t, input f, input m, input v,
    input [31:0] e, input [31:0] k);
    fc <= c;
    fx <= x;
    ft <= t;
    ff <= f;
    fm <= m;
    frag_valid <= 1'h1;
    @(posedge clk);
    frag_valid <= 1'h0;
    #1;
    chk("pix_valid", {31'h0, v}, {31'h0, pv});
    if (v) chk("pix_data", e & k, pd & k);
    @(posedge clk);
  endtask
  task prim;
    prim_start <= 1'h1;
    @(posedge clk);
    prim_start <= 1'h0;
    @(posedge clk);
  endtask
  function [31:0] lop(input [3:0] o, input [31:0] s, input [31:0] d);
    case (o)
      4'h0: lop = 32'h00000000;
      4'h3: lop = s;
      4'h6: lop = s ^ d;
      default: lop = 32'hFFFFFFFF;
    endcase
  endfunction
  task end_sim;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    #20000;
    err_count++;
    end_sim;
  end
  // test sequence
  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1'h1;
    @(posedge clk);
    rd(`FCB_A_TEX_CTL, 32'h00000000);
    rd(8'h80, 32'h00000000);
    bus(1'h1, `FCB_A_BLEND, 32'h00000003);
    rd(`FCB_A_BLEND, 32'h00000003);
    bus(1'h1, `FCB_A_BLEND, 32'h00000000);
    frag(C, 16'h0, 1'h0, 1'h0, 1'h0, 1'h1, C, 32'hFFFFFFFF);
    bus(1'h1, `FCB_A_TEXEL, T);
    bus(1'h1, `FCB_A_TEX_CTL, 32'h00000001);
    frag(C, 16'h0, 1'h1, 1'h0, 1'h0, 1'h1, T, 32'h00FFFFFF);
    frag(C, 16'h0, 1'h0, 1'h0, 1'h0, 1'h1, C, 32'hFFFFFFFF);
    // ramp, no decal, modulate by a diffuse term of one half
    bus(1'h1, 8'h14, 32'h00008000);
    bus(1'h1, `FCB_A_TEX_CTL, 32'h00000123);
    prim;
    frag(C, 16'h0, 1'h1, 1'h0, 1'h0, 1'h1, 32'h05111A22, 32'hFFFFFFFF);
    // diffuse interpolator off: modulate term reads zero
    bus(1'h1, `FCB_A_TEX_CTL, 32'h00000023);
    prim;
    frag(C, 16'h0, 1'h1, 1'h0, 1'h0, 1'h1, 32'h00000000, 32'hFFFFFFFF);
    bus(1'h1, `FCB_A_TEX_CTL, 32'h00000000);
    frag(C, 16'h0, 1'h0, 1'h0, 1'h1, 1'h1, T, 32'h00FFFFFF);
    // texture reader load: same-cycle fragment sees it, then it is held
    tl <= 1'h1;
    ti <= 32'h55667788;
    frag(C, 16'h0, 1'h0, 1'h0, 1'h1, 1'h1, 32'h55667788, 32'hFFFFFFFF);
    tl <= 1'h0;
    frag(C, 16'h0, 1'h0, 1'h0, 1'h1, 1'h1, 32'h55667788, 32'hFFFFFFFF);
    bus(1'h1, `FCB_A_HAZE_COL, 32'h00A0B0C0);
    bus(1'h1, `FCB_A_HAZE_CTL, 32'h00000001);
    bus(1'h1, 8'h20, 32'h00000000);
    prim;
    frag(C, 16'h0, 1'h0, 1'h1, 1'h0, 1'h1, {C[31:24], 24'hA0B0C0}, 32'hFFFFFFFF);
    frag(C, 16'h0, 1'h0, 1'h0, 1'h0, 1'h1, C, 32'hFFFFFFFF);
    // one dominant edge step of 1.0 takes fog to no haze
    bus(1'h1, 8'h28, 32'h00010000);
    edge_step <= 1'h1;
    @(posedge clk);
    edge_step <= 1'h0;
    frag(C, 16'h0, 1'h0, 1'h1, 1'h0, 1'h1, C, 32'hFFFFFFFF);
    bus(1'h1, 8'h20, 32'h00010000);
    prim;
    frag(C, 16'h0, 1'h0, 1'h1, 1'h0, 1'h1, C, 32'hFFFFFFFF);
    bus(1'h1, `FCB_A_HAZE_CTL, 32'h00000003);
    bus(1'h1, 8'h20, 32'hFFFFFFFF);
    prim;
    frag(C, 16'h0, 1'h0, 1'h1, 1'h0, 1'h0, C, 32'h00000000);
    bus(1'h1, `FCB_A_HAZE_CTL, 32'h00000000);
    bus(1'h1, `FCB_A_BLEND, 32'h00000003);
    frag(32'hFF102030, 16'h4, 1'h0, 1'h0, 1'h0, 1'h1, 32'hFF102030, 32'hFFFFFFFF);
    frag(32'h00102030, 16'h5, 1'h0, 1'h0, 1'h0, 1'h1, 32'h003C0005, 32'hFFFFFFFF);
    bus(1'h1, `FCB_A_BLEND, 32'h00000005);
    frag(32'h00102030, 16'h6, 1'h0, 1'h0, 1'h0, 1'h1, 32'h004C2036, 32'hFFFFFFFF);
    bus(1'h1, `FCB_A_BLEND, 32'h00000000);
    bus(1'h1, `FCB_A_PIXFMT, 32'h00001001);
    frag(C, 16'h0, 1'h0, 1'h0, 1'h0, 1'h1, {8'h00, C[23:0]}, 32'hFFFFFFFF);
    bus(1'h1, `FCB_A_PIXFMT, 32'h00002001);
    frag(C, 16'h0, 1'h0, 1'h0, 1'h0, 1'h1, {8'hF8, C[23:0]}, 32'hFFFFFFFF);
    // 565 in both orders, then colour index replicated
    bus(1'h1, `FCB_A_PIXFMT, 32'h00000009);
    frag(C, 16'h0, 1'h0, 1'h0, 1'h0, 1'h1, 32'h00004102, 32'hFFFFFFFF);
    bus(1'h1, `FCB_A_PIXFMT, 32'h00000089);
    frag(C, 16'h0, 1'h0, 1'h0, 1'h0, 1'h1, 32'h00001108, 32'hFFFFFFFF);
    bus(1'h1, `FCB_A_PIXFMT, 32'h00000015);
    frag(C, 16'h0, 1'h0, 1'h0, 1'h0, 1'h1, 32'h10101010, 32'hFFFFFFFF);
    bus(1'h1, `FCB_A_PIXFMT, 32'h00000000);
    for (i = 0; i < 4; i++) begin
      op = (i == 0) ? 4'h0 : (i == 1) ? 4'h3 : (i == 2) ? 4'h6 : 4'hF;
      bus(1'h1, `FCB_A_BITOP, {27'h0, op, 1'h1});
      frag(C, 16'h7 + i[15:0], 1'h0, 1'h0, 1'h0, 1'h1,
        lop(op, C, {28'h5A3C000, 4'h7 + i[3:0]}), 32'hFFFFFFFF);
    end
    bus(1'h1, `FCB_A_CONST, 32'h12345678);
    bus(1'h1, `FCB_A_BITOP, 32'h00000020);
    frag(C, 16'h0, 1'h1, 1'h1, 1'h0, 1'h1, 32'h12345678, 32'hFFFFFFFF);
    bus(1'h1, `FCB_A_BITOP, 32'h00000000);
    // one discarded fragment, twenty-five written
    rd(`FCB_A_STATUS, 32'h00010019);
    end_sim;
  end
endmodule
bind fcb_backend fcb_backend_monitor #(.CW(CW)) i_fcb_backend_monitor (.clk(clk),
  .reset_n(reset_n), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hreadyout(hreadyout),
  .hrdata(hrdata), .hresp(hresp), .frag_valid(frag_valid), .frag_x(frag_x),
  .frag_y(frag_y), .pix_valid(pix_valid), .pix_x(pix_x), .pix_y(pix_y),
  .pix_data(pix_data));
`default_nettype wire
